// ==== hdl/boot_cfg_pkg.sv ====
// Constants for the boot strap capture block
package boot_cfg_pkg;
  localparam logic [31:0] strap_reg_addr = 32'h01c40014;
  // Bit positions in the capture register
  localparam int boot_mode_lsb = 0;
  localparam int ext_pinout_lsb = 8;
  localparam int multiplier_lsb = 12;
  localparam int cs2_width_bit = 16;
  localparam int host_bus_bit = 17;
  localparam int fast_boot_bit = 19;
  localparam int endian_bit = 20;
  // Reserved field at 31:21 reads 0000 0000 001b
  localparam logic [10:0] upper_reserved = 11'h001;
  localparam int upper_lsb = 21;
  // Boot mode codes
  localparam logic [3:0] mode_pci_a = 4'h1;
  localparam logic [3:0] mode_pci_b = 4'h2;
  localparam logic [3:0] mode_i2c = 4'h5;
  localparam logic [3:0] mode_spi16 = 4'h6;
  localparam logic [3:0] mode_uart_a = 4'h8;
  localparam logic [3:0] mode_uart_b = 4'he;
  localparam logic [3:0] mode_spi24 = 4'h3;
  localparam logic [3:0] mode_host_port = 4'hb;
  // Boot-time peripheral clock settings
  localparam logic [7:0] i2c_prescale_val = 8'h02;
  localparam logic [7:0] i2c_fast_count = 8'h08;
  localparam logic [7:0] i2c_std_count = 8'h2d;
  localparam logic [15:0] uart_divisor_val = 16'h000f;
  localparam logic [7:0] spi_divider_val = 8'h02;
  localparam logic [2:0] periph_div_last = 3'h5;
endpackage : boot_cfg_pkg

// ==== hdl/strap_if.sv ====
// Captured strap fields passed between the capture and decode logic
`timescale 1ns/1ps
`default_nettype none
interface strap_if;
  logic [3:0] boot_mode;
  logic fast_boot;
  logic [2:0] ext_pinout_default;
  logic [2:0] boot_multiplier_select;
  logic cs2_width;
  logic host_bus_pin_default;
  logic endian_select;
  modport src (output boot_mode, fast_boot, ext_pinout_default, boot_multiplier_select,
    cs2_width, host_bus_pin_default, endian_select);
  modport dst (input boot_mode, fast_boot, ext_pinout_default, boot_multiplier_select,
    cs2_width, host_bus_pin_default, endian_select);
endinterface : strap_if
`default_nettype wire

// ==== hdl/boot_clock_setup.sv ====
// Decodes the captured boot mode into boot-time peripheral clock settings
`timescale 1ns/1ps
`default_nettype none
module boot_clock_setup (
  input wire logic clk,
  input wire logic rst_n,
  strap_if.dst straps,
  output logic [7:0] i2c_prescale,
  output logic [7:0] i2c_scl_low_count,
  output logic [7:0] i2c_scl_high_count,
  output logic i2c_fast_mode,
  output logic i2c_boot_sel,
  output logic [15:0] uart_divisor,
  output logic uart_boot_sel,
  output logic [7:0] serial_port_clock_divider,
  output logic spi_boot_sel,
  output logic pci_boot_allowed,
  output logic host_port_boot_sel
);
  import boot_cfg_pkg::*;

  logic [7:0] psc_nxt, low_nxt, high_nxt, div_nxt;
  logic [15:0] uart_nxt;
  logic fast_nxt, i2c_nxt, uart_sel_nxt, spi_nxt, pci_nxt, hpi_nxt;

  always_comb begin
    psc_nxt = 8'h00;
    low_nxt = 8'h00;
    high_nxt = 8'h00;
    fast_nxt = 1'b0;
    i2c_nxt = 1'b0;
    uart_nxt = 16'h0000;
    uart_sel_nxt = 1'b0;
    div_nxt = 8'h00;
    spi_nxt = 1'b0;
    pci_nxt = 1'b0;
    hpi_nxt = 1'b0;
    if (straps.boot_mode == mode_i2c) begin
      i2c_nxt = 1'b1;
      psc_nxt = i2c_prescale_val; // [RQ7] [RQ8]
      fast_nxt = straps.fast_boot; // [RQ6]
      low_nxt = straps.fast_boot ? i2c_fast_count : i2c_std_count; // [RQ7] [RQ8]
      high_nxt = straps.fast_boot ? i2c_fast_count : i2c_std_count; // [RQ7] [RQ8]
    end
    if (straps.boot_mode == mode_uart_a || straps.boot_mode == mode_uart_b) begin
      uart_sel_nxt = 1'b1;
      uart_nxt = uart_divisor_val; // [RQ10]
    end
    if (straps.boot_mode == mode_spi16 || straps.boot_mode == mode_spi24) begin
      spi_nxt = 1'b1;
      div_nxt = spi_divider_val; // [RQ11]
    end
    // PCI needs the enable strap and fast boot together
    pci_nxt = (straps.boot_mode == mode_pci_a || straps.boot_mode == mode_pci_b)
      && straps.host_bus_pin_default && straps.fast_boot; // [RQ13]
    hpi_nxt = straps.boot_mode == mode_host_port; // [RQ14]
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      i2c_prescale <= 8'h00;
      i2c_scl_low_count <= 8'h00;
      i2c_scl_high_count <= 8'h00;
      i2c_fast_mode <= 1'b0;
      i2c_boot_sel <= 1'b0;
      uart_divisor <= 16'h0000;
      uart_boot_sel <= 1'b0;
      serial_port_clock_divider <= 8'h00;
      spi_boot_sel <= 1'b0;
      pci_boot_allowed <= 1'b0;
      host_port_boot_sel <= 1'b0;
    end else begin
      i2c_prescale <= psc_nxt;
      i2c_scl_low_count <= low_nxt;
      i2c_scl_high_count <= high_nxt;
      i2c_fast_mode <= fast_nxt;
      i2c_boot_sel <= i2c_nxt;
      uart_divisor <= uart_nxt;
      uart_boot_sel <= uart_sel_nxt;
      serial_port_clock_divider <= div_nxt;
      spi_boot_sel <= spi_nxt;
      pci_boot_allowed <= pci_nxt;
      host_port_boot_sel <= hpi_nxt;
    end
  end

  i2c_counts_a: assert property (@(posedge clk) disable iff (!rst_n) // [RQ7]
    (straps.boot_mode == mode_i2c) |=> (i2c_prescale == 8'h02) &&
    (i2c_scl_low_count == ($past(straps.fast_boot) ? 8'h08 : 8'h2d)))
    else $error("i2c boot counts wrong");
  i2c_speed_a: assert property (@(posedge clk) disable iff (!rst_n) // [RQ6]
    (straps.boot_mode == mode_i2c) |=> i2c_fast_mode == $past(straps.fast_boot))
    else $error("i2c speed mismatch");
  i2c_std_a: assert property (@(posedge clk) disable iff (!rst_n) // [RQ8]
    (straps.boot_mode == mode_i2c && !straps.fast_boot) |=> i2c_scl_high_count == 8'h2d)
    else $error("i2c standard count wrong");
  uart_div_a: assert property (@(posedge clk) disable iff (!rst_n) // [RQ10]
    (straps.boot_mode == mode_uart_b) |=> uart_divisor == 16'h000f && uart_boot_sel)
    else $error("uart divisor wrong");
  spi_div_a: assert property (@(posedge clk) disable iff (!rst_n) // [RQ11]
    (straps.boot_mode == mode_spi16) |=> serial_port_clock_divider == 8'h02)
    else $error("spi divider wrong");
  pci_gate_a: assert property (@(posedge clk) disable iff (!rst_n) // [RQ13]
    pci_boot_allowed |-> $past(straps.fast_boot) && $past(straps.host_bus_pin_default))
    else $error("pci boot offered without fast boot and enable");
  hpi_both_a: assert property (@(posedge clk) disable iff (!rst_n) // [RQ14]
    (straps.boot_mode == mode_host_port) |=> host_port_boot_sel)
    else $error("host port boot refused");
endmodule : boot_clock_setup
`default_nettype wire

// ==== hdl/boot_strap_capture.sv ====
// Boot and configuration strap capture with read-only status register
//
// Summary of operation
// RQ1: The strap pins sampled at reset are held in a read-only capture register.
// RQ2: Fields take the strap levels at reset release and hold them until the next reset.
// RQ3: The capture register answers reads at its fixed system address 0x01c40014.
// RQ4: Writes to reserved fields change no stored value.
// RQ5: The endian field reads 0 for big endian and 1 for little endian as strapped.
// RQ6: I2C boot mode 0101 runs standard speed without fast boot and fast speed with it.
// RQ7: Fast I2C boot uses prescale 2 and low and high counts of 8.
// RQ8: Standard I2C boot uses prescale 2 and low and high counts of 45.
// RQ9: The board keeps the input clock within 21 to 30 MHz when choosing I2C boot.
// RQ10: UART boot codes 1000 and 1110 load the first UART divisor with 15 at 16x sampling.
// RQ11: Both SPI boot variants use the serial port with clock divider setting 2.
// RQ12: During boot the peripheral clock runs at one sixth of the main device clock.
// RQ13: PCI boot codes 0001 and 0010 need the host bus enable strap and fast boot.
// RQ14: Host port boot is supported with and without fast boot.
// RQ15: The fast boot field reads 0 for none and 1 for fast boot, as strapped.
// RQ16: The chip-select-2 width field reads 0 for 8-bit and 1 for 16-bit and seeds memory width.
// RQ17: All register writes are ignored and reads return the values captured at reset.
`timescale 1ns/1ps
`default_nettype none
module boot_strap_capture (
  input wire logic clk,
  input wire logic rst_n,
  // Strap pins
  input wire logic [3:0] boot_mode_pins,
  input wire logic fast_boot_pin,
  input wire logic [2:0] ext_pinout_pins,
  input wire logic [2:0] multiplier_pins,
  input wire logic cs2_width_pin,
  input wire logic host_bus_enable_strap,
  input wire logic endian_pin,
  // System module access
  input wire logic [31:0] sys_addr,
  input wire logic sys_rd,
  input wire logic sys_wr,
  input wire logic [31:0] sys_wdata,
  output logic [31:0] sys_rdata,
  output logic sys_hit,
  // Boot-time settings
  output logic endian_select,
  output logic ext_mem_width_default,
  output logic host_bus_pin_default,
  output logic [2:0] ext_pinout_default,
  output logic [2:0] boot_multiplier_select,
  output logic [7:0] i2c_prescale,
  output logic [7:0] i2c_scl_low_count,
  output logic [7:0] i2c_scl_high_count,
  output logic i2c_fast_mode,
  output logic i2c_boot_sel,
  output logic [15:0] uart_divisor,
  output logic uart_boot_sel,
  output logic [7:0] serial_port_clock_divider,
  output logic spi_boot_sel,
  output logic pci_boot_allowed,
  output logic host_port_boot_sel,
  output logic peripheral_clock_en
);
  import boot_cfg_pkg::*;

  // ----------------------------------------------------------------
  // Strap capture
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    st_reset = 2'b01,
    st_held = 2'b10
  } cap_state_e;

  cap_state_e state_r, state_nxt;
  logic [3:0] mode_r, mode_nxt;
  logic fast_r, fast_nxt;
  logic [2:0] pinout_r, pinout_nxt;
  logic [2:0] mult_r, mult_nxt;
  logic width_r, width_nxt;
  logic host_bus_enable_strap_r, host_bus_enable_strap_nxt;
  logic endian_r, endian_nxt;

  // Straps are caught on the first edge after release, not under reset
  always_comb begin
    state_nxt = state_r;
    mode_nxt = mode_r;
    fast_nxt = fast_r;
    pinout_nxt = pinout_r;
    mult_nxt = mult_r;
    width_nxt = width_r;
    host_bus_enable_strap_nxt = host_bus_enable_strap_r;
    endian_nxt = endian_r;
    case (state_r)
      st_reset: begin
        mode_nxt = boot_mode_pins; // [RQ1] [RQ2]
        fast_nxt = fast_boot_pin; // [RQ15]
        pinout_nxt = ext_pinout_pins;
        mult_nxt = multiplier_pins;
        width_nxt = cs2_width_pin; // [RQ16]
        host_bus_enable_strap_nxt = host_bus_enable_strap;
        endian_nxt = endian_pin; // [RQ5]
        state_nxt = st_held;
      end
      st_held: state_nxt = st_held; // [RQ2]
      default: state_nxt = st_reset;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_r <= st_reset;
      mode_r <= 4'h0;
      fast_r <= 1'b0;
      pinout_r <= 3'h0;
      mult_r <= 3'h0;
      width_r <= 1'b0;
      host_bus_enable_strap_r <= 1'b0;
      endian_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      mode_r <= mode_nxt;
      fast_r <= fast_nxt;
      pinout_r <= pinout_nxt;
      mult_r <= mult_nxt;
      width_r <= width_nxt;
      host_bus_enable_strap_r <= host_bus_enable_strap_nxt;
      endian_r <= endian_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Register read port
  // ----------------------------------------------------------------
  logic [31:0] image;
  logic [31:0] rdata_nxt;
  logic hit;

  // Writes never reach the fields; sys_wdata is deliberately unused
  always_comb begin
    image = 32'h00000000;
    image[boot_mode_lsb +: 4] = mode_r;
    image[ext_pinout_lsb +: 3] = pinout_r;
    image[multiplier_lsb +: 3] = mult_r;
    image[cs2_width_bit] = width_r;
    image[host_bus_bit] = host_bus_enable_strap_r;
    image[fast_boot_bit] = fast_r; // [RQ15]
    image[endian_bit] = endian_r; // [RQ5]
    image[upper_lsb +: 11] = upper_reserved; // [RQ4]
    hit = sys_addr == strap_reg_addr; // [RQ3]
    rdata_nxt = (sys_rd && hit) ? image : 32'h00000000; // [RQ17]
  end

  logic [31:0] rdata_r;
  logic hit_r;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdata_r <= 32'h00000000;
      hit_r <= 1'b0;
    end else begin
      rdata_r <= rdata_nxt;
      hit_r <= sys_rd && hit;
    end
  end
  assign sys_rdata = rdata_r;
  assign sys_hit = hit_r;

  // ----------------------------------------------------------------
  // Peripheral clock enable, one sixth of the main clock
  // ----------------------------------------------------------------
  logic [2:0] div_r, div_nxt;
  always_comb begin
    div_nxt = (div_r == periph_div_last) ? 3'h0 : div_r + 3'h1; // [RQ12]
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      div_r <= 3'h0;
    end else begin
      div_r <= div_nxt;
    end
  end
  assign peripheral_clock_en = div_r == periph_div_last; // [RQ12]

  // ----------------------------------------------------------------
  // Boot-time clock settings
  // ----------------------------------------------------------------
  strap_if straps ();
  assign straps.boot_mode = mode_r;
  assign straps.fast_boot = fast_r;
  assign straps.ext_pinout_default = pinout_r;
  assign straps.boot_multiplier_select = mult_r;
  assign straps.cs2_width = width_r;
  assign straps.host_bus_pin_default = host_bus_enable_strap_r;
  assign straps.endian_select = endian_r;

  boot_clock_setup u_setup (
    .clk(clk),
    .rst_n(rst_n),
    .straps(straps),
    .i2c_prescale(i2c_prescale),
    .i2c_scl_low_count(i2c_scl_low_count),
    .i2c_scl_high_count(i2c_scl_high_count),
    .i2c_fast_mode(i2c_fast_mode),
    .i2c_boot_sel(i2c_boot_sel),
    .uart_divisor(uart_divisor),
    .uart_boot_sel(uart_boot_sel),
    .serial_port_clock_divider(serial_port_clock_divider),
    .spi_boot_sel(spi_boot_sel),
    .pci_boot_allowed(pci_boot_allowed),
    .host_port_boot_sel(host_port_boot_sel)
  );

  assign endian_select = endian_r;
  assign ext_mem_width_default = width_r; // [RQ16]
  assign host_bus_pin_default = host_bus_enable_strap_r;
  assign ext_pinout_default = pinout_r;
  assign boot_multiplier_select = mult_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence read_hit_s;
    sys_rd && (sys_addr == strap_reg_addr);
  endsequence

  sequence capture_s;
    state_r == st_reset;
  endsequence

  sequence held_s;
    state_r == st_held;
  endsequence

  // Five quiet cycles, then the next pulse
  sequence periph_gap_s;
    !peripheral_clock_en [*5] ##1 peripheral_clock_en;
  endsequence

  held_value_a: assert property (@(posedge clk) disable iff (!rst_n) // [RQ2]
    held_s |=> $stable(mode_r) && $stable(endian_r) && $stable(fast_r))
    else $error("captured straps changed after capture");

  held_rest_a: assert property (@(posedge clk) disable iff (!rst_n) // [RQ2]
    held_s |=> $stable(pinout_r) && $stable(mult_r) && $stable(width_r)
      && $stable(host_bus_enable_strap_r))
    else $error("captured fields changed after capture");

  state_onehot_a: assert property (@(posedge clk) disable iff (!rst_n) // [RQ2]
    $onehot(state_r))
    else $error("capture state not one-hot");

  capture_edge_a: assert property (@(posedge clk) disable iff (!rst_n) // [RQ1]
    capture_s |=> mode_r == $past(boot_mode_pins) && state_r == st_held)
    else $error("boot mode not caught at release");

  capture_fields_a: assert property (@(posedge clk) disable iff (!rst_n) // [RQ1]
    capture_s |=> pinout_r == $past(ext_pinout_pins) && mult_r == $past(multiplier_pins)
      && width_r == $past(cs2_width_pin))
    else $error("pinout, multiplier or width not caught at release");

  capture_flags_a: assert property (@(posedge clk) disable iff (!rst_n) // [RQ15]
    capture_s |=> fast_r == $past(fast_boot_pin) && endian_r == $past(endian_pin)
      && host_bus_enable_strap_r == $past(host_bus_enable_strap))
    else $error("fast boot, endian or host bus strap not caught");

  read_image_a: assert property (@(posedge clk) disable iff (!rst_n) // [RQ3]
    read_hit_s |=> sys_hit && sys_rdata[31:21] == 11'h001 && sys_rdata[3:0] == $past(mode_r))
    else $error("capture register read wrong");

  endian_read_a: assert property (@(posedge clk) disable iff (!rst_n) // [RQ5]
    read_hit_s |=> sys_rdata[20] == $past(endian_r) && sys_rdata[19] == $past(fast_r))
    else $error("endian or fast boot field wrong");

  read_fields_a: assert property (@(posedge clk) disable iff (!rst_n) // [RQ1]
    read_hit_s |=> sys_rdata[14:12] == $past(mult_r) && sys_rdata[10:8] == $past(pinout_r)
      && sys_rdata[17] == $past(host_bus_enable_strap_r))
    else $error("multiplier, pinout or host bus field wrong");

  write_ignored_a: assert property (@(posedge clk) disable iff (!rst_n) // [RQ17]
    (sys_wr && state_r == st_held) |=> $stable(mode_r) && $stable(pinout_r) && $stable(width_r))
    else $error("write disturbed captured value");

  reserved_zero_a: assert property (@(posedge clk) disable iff (!rst_n) // [RQ4]
    read_hit_s |=> sys_rdata[18] == 1'b0 && sys_rdata[15] == 1'b0 && sys_rdata[7:4] == 4'h0)
    else $error("reserved bits not zero");

  reserved_mid_a: assert property (@(posedge clk) disable iff (!rst_n) // [RQ4]
    read_hit_s |=> sys_rdata[11] == 1'b0 && sys_rdata[31:21] == upper_reserved)
    else $error("reserved field value wrong");

  idle_read_a: assert property (@(posedge clk) disable iff (!rst_n) // [RQ3]
    !(sys_rd && sys_addr == strap_reg_addr)
      |=> !sys_hit && sys_rdata == 32'h00000000)
    else $error("read answer without a read of the register");

  hit_from_read_a: assert property (@(posedge clk) disable iff (!rst_n) // [RQ3]
    sys_hit |-> $past(sys_rd) && $past(sys_addr) == strap_reg_addr)
    else $error("hit without a matching read");

  width_seed_a: assert property (@(posedge clk) disable iff (!rst_n) // [RQ16]
    read_hit_s |=> sys_rdata[16] == $past(ext_mem_width_default))
    else $error("width field mismatch");

  periph_rate_a: assert property (@(posedge clk) disable iff (!rst_n) // [RQ12]
    peripheral_clock_en |=> periph_gap_s)
    else $error("peripheral clock not one sixth");
endmodule : boot_strap_capture
`default_nettype wire

// ==== bench/strap_board.sv ====
// Board-side model: strap resistors that set the configuration pins
`timescale 1ns/1ps
`default_nettype none
module strap_board #(
  parameter int input_clk_mhz = 25
) (
  input wire logic [13:0] cfg,
  output logic [3:0] boot_mode_pins,
  output logic fast_boot_pin,
  output logic [2:0] ext_pinout_pins,
  output logic [2:0] multiplier_pins,
  output logic cs2_width_pin,
  output logic host_bus_enable_strap,
  output logic endian_pin
);
  // Board only offers I2C boot with a reference clock in range
  localparam bit clk_in_range = (input_clk_mhz >= 21) && (input_clk_mhz <= 30);
  // Straps are static levels, so later changes only come from the bench
  assign {endian_pin, fast_boot_pin, host_bus_enable_strap, cs2_width_pin} = cfg[13:10];
  assign {multiplier_pins, ext_pinout_pins} = cfg[9:4];
  // Clock out of range: the board straps mode 0 rather than I2C boot
  assign boot_mode_pins = (cfg[3:0] == 4'h5 && !clk_in_range) ? 4'h0 : cfg[3:0];
endmodule : strap_board
`default_nettype wire

// ==== bench/boot_strap_capture_tb.sv ====
// Self-checking testbench for the boot strap capture block
`timescale 1ns/1ps
`default_nettype none
module boot_strap_capture_tb;
  import boot_cfg_pkg::*;
  // Starts low with no event, so the negedge monitor does not fire at time zero
  logic clk = 1'b0;
  logic rst_n, sys_rd, sys_wr;
  logic [31:0] sys_addr, sys_wdata, sys_rdata, seed;
  logic [13:0] cfg;
  logic [3:0] boot_mode_pins;
  logic [2:0] ext_pinout_pins, multiplier_pins, ext_pinout_default, boot_multiplier_select;
  logic fast_boot_pin, cs2_width_pin, host_bus_enable_strap, endian_pin, sys_hit;
  logic endian_select, ext_mem_width_default, host_bus_pin_default;
  logic [7:0] i2c_prescale, i2c_scl_low_count, i2c_scl_high_count, serial_port_clock_divider;
  logic i2c_fast_mode, i2c_boot_sel, uart_boot_sel, spi_boot_sel, pci_boot_allowed;
  logic host_port_boot_sel, peripheral_clock_en;
  logic [15:0] uart_divisor;
  logic [31:0] notes[$];
  int err_total, num_checks;
  logic [3:0] modes [8] = '{4'h1, 4'h2, mode_spi24, 4'h5, 4'h6, 4'h8, mode_host_port, 4'he};

  strap_board i_strap_board (.cfg(cfg), .boot_mode_pins(boot_mode_pins),
    .fast_boot_pin(fast_boot_pin), .ext_pinout_pins(ext_pinout_pins),
    .multiplier_pins(multiplier_pins), .cs2_width_pin(cs2_width_pin),
    .host_bus_enable_strap(host_bus_enable_strap), .endian_pin(endian_pin));

  boot_strap_capture i_boot_strap_capture (.clk(clk), .rst_n(rst_n),
    .boot_mode_pins(boot_mode_pins), .fast_boot_pin(fast_boot_pin),
    .ext_pinout_pins(ext_pinout_pins), .multiplier_pins(multiplier_pins),
    .cs2_width_pin(cs2_width_pin), .host_bus_enable_strap(host_bus_enable_strap),
    .endian_pin(endian_pin), .sys_addr(sys_addr), .sys_rd(sys_rd), .sys_wr(sys_wr),
    .sys_wdata(sys_wdata), .sys_rdata(sys_rdata), .sys_hit(sys_hit),
    .endian_select(endian_select), .ext_mem_width_default(ext_mem_width_default),
    .host_bus_pin_default(host_bus_pin_default), .ext_pinout_default(ext_pinout_default),
    .boot_multiplier_select(boot_multiplier_select), .i2c_prescale(i2c_prescale),
    .i2c_scl_low_count(i2c_scl_low_count), .i2c_scl_high_count(i2c_scl_high_count),
    .i2c_fast_mode(i2c_fast_mode), .i2c_boot_sel(i2c_boot_sel), .uart_divisor(uart_divisor),
    .uart_boot_sel(uart_boot_sel), .serial_port_clock_divider(serial_port_clock_divider),
    .spi_boot_sel(spi_boot_sel), .pci_boot_allowed(pci_boot_allowed),
    .host_port_boot_sel(host_port_boot_sel), .peripheral_clock_en(peripheral_clock_en));

  // ----------------------------------------
  // Clock, helpers and verdict
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : give_verdict

  // ----------------------------------------
  // Read monitor: every hit consumes the oldest note
  // ----------------------------------------
  always @(negedge clk) begin
    if (sys_hit === 1'b1) begin
      if (notes.size() == 0) check("unexpected sys_hit", 32'h1, 32'h0);
      else check("sys_rdata", sys_rdata, notes.pop_front());
    end else begin
      check("sys_hit", {31'h0, sys_hit}, 32'h0);
      check("idle sys_rdata", sys_rdata, 32'h0);
    end
  end

  // ----------------------------------------
  // One boot: reset, capture, settings, bus access
  // ----------------------------------------
  task automatic run_boot(input int j);
    logic [13:0] c;
    logic [31:0] e, cnt;
    logic [3:0] m;
    logic f, i2c, u, s;
    e = rnd();
    c = e[13:0];
    c[3:0] = modes[j % 8];
    c[12] = j[3];
    c[11] = j[4];
    m = c[3:0];
    f = c[12];
    e = {11'h001, c[13], f, 1'b0, c[11], c[10], 1'b0, c[9:7], 1'b0, c[6:4], 4'h0, m};
    @(negedge clk);
    rst_n = 1'b0;
    cfg = c;
    @(negedge clk);
    rst_n = 1'b1;
    // Straps move after the capture edge; the register must not follow
    @(negedge clk);
    cfg = ~c;
    for (int k = 2; k <= 12; k++) begin
      @(negedge clk);
      check("peripheral_clock_en", {31'h0, peripheral_clock_en}, {31'h0, k % 6 == 5});
    end
    i2c = (m == 4'h5);
    u = (m == 4'h8) || (m == 4'he);
    s = (m == 4'h6) || (m == mode_spi24);
    cnt = i2c ? (f ? 32'h8 : 32'h2d) : 32'h0;
    check("endian_select", {31'h0, endian_select}, {31'h0, c[13]});
    check("ext_mem_width", {31'h0, ext_mem_width_default}, {31'h0, c[10]});
    check("host_bus_pin", {31'h0, host_bus_pin_default}, {31'h0, c[11]});
    check("ext_pinout", {29'h0, ext_pinout_default}, {29'h0, c[6:4]});
    check("multiplier", {29'h0, boot_multiplier_select}, {29'h0, c[9:7]});
    check("i2c_prescale", {24'h0, i2c_prescale}, i2c ? 32'h2 : 32'h0);
    check("i2c_low", {24'h0, i2c_scl_low_count}, cnt);
    check("i2c_high", {24'h0, i2c_scl_high_count}, cnt);
    check("i2c_fast", {31'h0, i2c_fast_mode}, {31'h0, i2c & f});
    check("i2c_sel", {31'h0, i2c_boot_sel}, {31'h0, i2c});
    check("uart_divisor", {16'h0, uart_divisor}, u ? 32'hf : 32'h0);
    check("uart_sel", {31'h0, uart_boot_sel}, {31'h0, u});
    check("spi_divider", {24'h0, serial_port_clock_divider}, s ? 32'h2 : 32'h0);
    check("spi_sel", {31'h0, spi_boot_sel}, {31'h0, s});
    check("pci_allowed", {31'h0, pci_boot_allowed},
      {31'h0, (m == 4'h1 || m == 4'h2) && c[11] && f});
    check("host_port_sel", {31'h0, host_port_boot_sel}, {31'h0, m == mode_host_port});
    // Write all ones-complement, then reads back to back with an unmapped one between
    @(negedge clk);
    sys_wr = 1'b1;
    sys_addr = strap_reg_addr;
    sys_wdata = ~e;
    @(negedge clk);
    sys_wr = 1'b0;
    sys_rd = 1'b1;
    notes.push_back(e);
    @(negedge clk);
    sys_addr = strap_reg_addr + 32'h4;
    @(negedge clk);
    sys_addr = strap_reg_addr;
    notes.push_back(e);
    @(negedge clk);
    sys_rd = 1'b0;
    @(negedge clk);
    $display("test %0d mode %h fast %0d done", j, m, f);
  endtask : run_boot

  // ----------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------
  initial begin
    err_total = 0;
    num_checks = 0;
    seed = 32'he97d;
    rst_n = 1'b0;
    sys_rd = 1'b0;
    sys_wr = 1'b0;
    sys_addr = 32'h0;
    sys_wdata = 32'h0;
    cfg = 14'h0;
    repeat (2) @(negedge clk);
    for (int j = 0; j < 32; j++) run_boot(j);
    check("pending reads", notes.size(), 32'h0);
    give_verdict();
  end

  initial begin
    #50us;
    err_total++;
    $display("ERROR watchdog expected finish seen timeout");
    give_verdict();
  end
endmodule : boot_strap_capture_tb
`default_nettype wire
